// ---- logic/scmc_clk_switch.sv ----
// Glitch-free core clock source switch working on oscillator edge strobes
`timescale 1ns/1ps
`include "scmc_params.svh"

module scmc_clk_switch (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire scmc_pkg::scmc_cfg_type req_cfg,
  input  wire logic                  cur_tick,
  input  wire logic                  tgt_tick,
  output scmc_pkg::scmc_cfg_type     active_cfg,
  output scmc_pkg::scmc_cfg_type     pending_cfg,
  output logic                       busy,
  output logic                       core_tick
);

  typedef enum logic [1:0] {
    SW_STEADY = 2'b00,
    SW_DRAIN  = 2'b01,
    SW_TARGET = 2'b10
  } scmc_sw_state_type;

  scmc_sw_state_type      state_q;
  scmc_pkg::scmc_cfg_type active_q;
  scmc_pkg::scmc_cfg_type pending_q;
  logic [2:0]             drain_q;

  // Drain whole current periods, then hand over on the first target edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= SW_STEADY;
      active_q  <= '0;
      pending_q <= '0;
      drain_q   <= 3'h0;
    end else begin
      case (state_q)
        SW_STEADY: begin
          if (req_cfg != active_q) begin
            pending_q <= req_cfg;
            drain_q   <= 3'h0;
            state_q   <= SW_DRAIN;
          end
        end
        SW_DRAIN: begin
          if (cur_tick) begin
            drain_q <= drain_q + 3'h1;
            if (drain_q == `SCMC_SWITCH_PERIODS - 3'h1) begin
              state_q <= SW_TARGET; // R17
            end
          end
        end
        SW_TARGET: begin
          if (tgt_tick) begin
            active_q <= pending_q; // R17
            state_q  <= SW_STEADY;
          end
        end
        default: state_q <= SW_STEADY;
      endcase
    end
  end

  // Silence between the last old edge and the first new edge: no runt periods
  assign core_tick   = (state_q == SW_TARGET) ? tgt_tick : cur_tick; // R18
  assign busy        = (state_q != SW_STEADY);
  assign active_cfg  = active_q;
  assign pending_cfg = pending_q;

endmodule : scmc_clk_switch

// ---- logic/scmc_params.svh ----
// Register map, field positions, reset values and switch timing of the clock and mode control
`ifndef SCMC_PARAMS_SVH
`define SCMC_PARAMS_SVH

// Word offsets on the register bus
`define SCMC_OFS_SYS_CLK      8'h00
`define SCMC_OFS_FAST_RC      8'h04
`define SCMC_OFS_FAST_XTAL    8'h08
`define SCMC_OFS_SLOW_XTAL    8'h0C
`define SCMC_OFS_STATUS       8'h10

// Field positions inside the system clock register
`define SCMC_SCC_SEL_MSB      7
`define SCMC_SCC_SEL_LSB      5
`define SCMC_SCC_HI_SRC       3
`define SCMC_SCC_LO_SRC       2
`define SCMC_SCC_HI_KEEP      1
`define SCMC_SCC_LO_KEEP      0

// Field positions inside the oscillator registers
`define SCMC_OSC_MODE_MSB     3
`define SCMC_OSC_MODE_LSB     2
`define SCMC_OSC_FLAG         1
`define SCMC_OSC_EN           0

// Reset values
`define SCMC_RST_SYS_CLK      8'h00
`define SCMC_RST_FAST_RC      8'h01
`define SCMC_RST_FAST_XTAL    8'h00
`define SCMC_RST_SLOW_XTAL    8'h00

// Select code of the sub clock
`define SCMC_SEL_SUB          3'h7

// Whole current-clock periods that a source switch lets pass before it waits for the target
`define SCMC_SWITCH_PERIODS   3'h4

`endif

// ---- logic/scmc_pkg.sv ----
// Types shared by the clock and mode control
package scmc_pkg;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_FAST  = 3'b000,
    MODE_SLOW  = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_IDLE_SLOW_ON = 3'b011,
    MODE_IDLE_BOTH_ON = 3'b100,
    MODE_IDLE_FAST_ON = 3'b101
  } scmc_mode_type;

  // Core clock source configuration that the switch moves between
  typedef struct packed {
    logic [2:0] sys_clk_sel;
    logic       hi_src_sel;
    logic       lo_src_sel;
  } scmc_cfg_type;

  // System clock register layout
  typedef struct packed {
    logic [2:0] sys_clk_sel;
    logic       unused;
    logic       hi_src_sel;
    logic       lo_src_sel;
    logic       hi_keep_on_halt;
    logic       lo_keep_on_halt;
  } scmc_scc_type;

  // Oscillator register layout, low nibble
  typedef struct packed {
    logic [1:0] mode;
    logic       stable_flag;
    logic       enable;
  } scmc_osc_type;

  // Captured AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } scmc_aphase_type;

endpackage : scmc_pkg

// ---- logic/scmc_top.sv ----
// System clock selection and operating mode control with an AHB-Lite register slave
// Contract
// R1: sel 000-110 fast clock, 111 sub clock
// R2: hi_src_sel picks fast crystal or fast RC
// R3: lo_src_sel picks slow crystal or slow RC
// R4: fast run divides fast clock 1 to 64
// R5: fast oscillator after switch follows its enable
// R6: six modes, CPU clock stops in four
// R7: halt with keeps 00 enters sleep, all off
// R8: sleep keeps slow RC only with watchdog
// R9: halt keeps 01 enters idle_slow_on
// R10: halt keeps 11 enters idle_both_on, all run
// R11: halt keeps 10 enters idle_fast_on
// R12: slow run from sub clock, fast by enable
// R13: fast run keeps every clock running
// R14: four 8-bit registers with given fields
// R15: sel decodes to divide by 1,2,4..64, sub
// R16: source select 0 internal RC, 1 crystal
// R17: switch waits four current periods plus sync
// R18: switching produces no glitch or runt pulse
`timescale 1ns/1ps
`include "scmc_params.svh"

module scmc_top #(
  parameter int DIV_W = 6
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        fast_rc_tick,
  input  wire logic        fast_xtal_tick,
  input  wire logic        slow_rc_tick,
  input  wire logic        slow_xtal_tick,
  input  wire logic        fast_rc_ready,
  input  wire logic        fast_xtal_ready,
  input  wire logic        slow_xtal_ready,
  input  wire logic        watchdog_en,
  input  wire logic        halt_req,
  input  wire logic        wake_req,
  output logic             core_clk_tick,
  output logic             cpu_clk_tick,
  output logic             fast_clk_tick,
  output logic             sub_clk_tick,
  output logic             slow_rc_clk_tick,
  output logic             fast_rc_osc_on,
  output logic             fast_xtal_osc_on,
  output logic             slow_xtal_osc_on,
  output logic             slow_rc_osc_on,
  output logic [2:0]       op_mode,
  output logic             switch_busy
);

  scmc_pkg::scmc_scc_type    scc_q;
  scmc_pkg::scmc_osc_type    fast_rc_q;
  scmc_pkg::scmc_osc_type    fast_xtal_q;
  scmc_pkg::scmc_osc_type    slow_xtal_q;
  scmc_pkg::scmc_mode_type   mode_q;
  scmc_pkg::scmc_aphase_type aph_q;
  scmc_pkg::scmc_cfg_type    req_cfg;
  scmc_pkg::scmc_cfg_type    act_cfg;
  scmc_pkg::scmc_cfg_type    pend_cfg;
  logic [DIV_W-1:0]          rc_cnt_q;
  logic [DIV_W-1:0]          xt_cnt_q;
  logic [31:0]               hrdata_q;
  logic [7:0]                rd_val;
  logic                      in_run;
  logic                      fast_run;
  logic                      sub_run;
  logic                      core_run;
  logic                      internal_slow_rc_run;
  logic                      fast_src_tick;
  logic                      sub_src_tick;
  logic                      cur_raw;
  logic                      tgt_raw;
  logic                      sw_core_tick;
  logic                      wr_fast_rc;
  logic                      wr_fast_xtal;
  logic                      wr_slow_xtal;
  logic                      sub_locked;
  logic                      fast_osc_on_q;
  logic                      fxt_osc_on_q;
  logic                      sxt_osc_on_q;
  logic                      internal_slow_rc_on_q;

  // Edge strobe of one source configuration, divided by 2^sel on the fast side
  function automatic logic sel_tick(
    input scmc_pkg::scmc_cfg_type cfg,
    input logic                   rc_t,
    input logic                   xt_t,
    input logic [DIV_W-1:0]       rc_c,
    input logic [DIV_W-1:0]       xt_c,
    input logic                   lrc_t,
    input logic                   lxt_t
  );
    logic [DIV_W-1:0] mask;
    logic [DIV_W-1:0] cnt;
    mask = ~({DIV_W{1'b1}} << cfg.sys_clk_sel);
    cnt  = cfg.hi_src_sel ? xt_c : rc_c; // R2 R16
    if (cfg.sys_clk_sel == `SCMC_SEL_SUB) begin
      sel_tick = cfg.lo_src_sel ? lxt_t : lrc_t; // R1 R3 R16
    end else begin
      sel_tick = (cfg.hi_src_sel ? xt_t : rc_t) && ((cnt & mask) == mask); // R4 R15
    end
  endfunction : sel_tick

  // Free-running dividers, one per fast source, so a source swap sees its own phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_cnt_q <= '0;
      xt_cnt_q <= '0;
    end else begin
      if (fast_rc_tick) begin
        rc_cnt_q <= rc_cnt_q + 1'b1;
      end
      if (fast_xtal_tick) begin
        xt_cnt_q <= xt_cnt_q + 1'b1;
      end
    end
  end

  // Requested configuration from the system clock register
  assign req_cfg.sys_clk_sel = scc_q.sys_clk_sel;
  assign req_cfg.hi_src_sel  = scc_q.hi_src_sel;
  assign req_cfg.lo_src_sel  = scc_q.lo_src_sel;

  // Clock strobes of the live and the pending configuration
  assign cur_raw = core_run && sel_tick(act_cfg, fast_rc_tick, fast_xtal_tick, rc_cnt_q, xt_cnt_q,
                                        slow_rc_tick, slow_xtal_tick);
  assign tgt_raw = sel_tick(pend_cfg, fast_rc_tick, fast_xtal_tick, rc_cnt_q, xt_cnt_q,
                            slow_rc_tick, slow_xtal_tick);

  scmc_clk_switch u_switch (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .req_cfg     (req_cfg),
    .cur_tick    (cur_raw),
    .tgt_tick    (tgt_raw),
    .active_cfg  (act_cfg),
    .pending_cfg (pend_cfg),
    .busy        (switch_busy),
    .core_tick   (sw_core_tick)
  );

  // Which clocks run in each mode
  always_comb begin
    in_run   = (mode_q == scmc_pkg::MODE_FAST) || (mode_q == scmc_pkg::MODE_SLOW); // R6
    fast_run = 1'b0;
    sub_run  = 1'b1;
    core_run = 1'b1;
    internal_slow_rc_run = 1'b1;
    case (mode_q)
      scmc_pkg::MODE_FAST: fast_run = 1'b1; // R13
      scmc_pkg::MODE_SLOW: fast_run = act_cfg.hi_src_sel ? fast_xtal_q.enable : fast_rc_q.enable; // R5 R12
      scmc_pkg::MODE_IDLE_SLOW_ON: begin
        core_run = (act_cfg.sys_clk_sel == `SCMC_SEL_SUB); // R9
      end
      scmc_pkg::MODE_IDLE_BOTH_ON: fast_run = 1'b1; // R10
      scmc_pkg::MODE_IDLE_FAST_ON: begin
        fast_run = 1'b1; // R11
        sub_run  = (act_cfg.sys_clk_sel == `SCMC_SEL_SUB);
        core_run = (act_cfg.sys_clk_sel != `SCMC_SEL_SUB);
      end
      scmc_pkg::MODE_SLEEP: begin
        sub_run  = 1'b0; // R7
        core_run = 1'b0;
        internal_slow_rc_run = watchdog_en; // R8
      end
      default: fast_run = 1'b0;
    endcase
  end

  // Peripheral strobes follow the live source selection
  assign fast_src_tick    = act_cfg.hi_src_sel ? fast_xtal_tick : fast_rc_tick;
  assign sub_src_tick     = act_cfg.lo_src_sel ? slow_xtal_tick : slow_rc_tick;
  assign fast_clk_tick    = fast_run && fast_src_tick;
  assign sub_clk_tick     = sub_run && sub_src_tick;
  assign slow_rc_clk_tick = internal_slow_rc_run && slow_rc_tick;
  assign core_clk_tick    = core_run && sw_core_tick; // R1
  assign cpu_clk_tick     = in_run && core_clk_tick; // R6
  assign op_mode          = mode_q;

  // Oscillator power requests; the switch target is kept running too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_osc_on_q <= 1'b1;
      fxt_osc_on_q  <= 1'b0;
      sxt_osc_on_q  <= 1'b0;
      internal_slow_rc_on_q     <= 1'b1;
    end else begin
      fast_osc_on_q <= fast_run && (!act_cfg.hi_src_sel || !pend_cfg.hi_src_sel); // R5
      fxt_osc_on_q  <= fast_run && (act_cfg.hi_src_sel || pend_cfg.hi_src_sel);
      sxt_osc_on_q  <= sub_run && (act_cfg.lo_src_sel || pend_cfg.lo_src_sel);
      internal_slow_rc_on_q     <= internal_slow_rc_run; // R8
    end
  end

  assign fast_rc_osc_on   = fast_osc_on_q;
  assign fast_xtal_osc_on = fxt_osc_on_q;
  assign slow_xtal_osc_on = sxt_osc_on_q;
  assign slow_rc_osc_on   = internal_slow_rc_on_q;

  // Halt picks the CPU-off mode from the keep bits; wake returns to run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= scmc_pkg::MODE_FAST;
    end else if (in_run && halt_req) begin
      case ({scc_q.hi_keep_on_halt, scc_q.lo_keep_on_halt})
        2'b00:   mode_q <= scmc_pkg::MODE_SLEEP; // R7
        2'b01:   mode_q <= scmc_pkg::MODE_IDLE_SLOW_ON; // R9
        2'b11:   mode_q <= scmc_pkg::MODE_IDLE_BOTH_ON; // R10
        default: mode_q <= scmc_pkg::MODE_IDLE_FAST_ON; // R11
      endcase
    end else if (in_run || wake_req) begin
      // Run flavour follows the live source, not the request still in flight
      mode_q <= (act_cfg.sys_clk_sel == `SCMC_SEL_SUB) ? scmc_pkg::MODE_SLOW : scmc_pkg::MODE_FAST; // R12 R13
    end
  end

  // AHB-Lite address phase capture; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= '0;
    end else if (hready) begin
      aph_q.valid <= hsel && htrans[1];
      aph_q.write <= hwrite;
      aph_q.addr  <= haddr;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Writes land at the end of the data phase
  assign wr_fast_rc   = aph_q.valid && aph_q.write && (aph_q.addr == `SCMC_OFS_FAST_RC);
  assign wr_fast_xtal = aph_q.valid && aph_q.write && (aph_q.addr == `SCMC_OFS_FAST_XTAL);
  assign wr_slow_xtal = aph_q.valid && aph_q.write && (aph_q.addr == `SCMC_OFS_SLOW_XTAL);
  // Slow crystal drive mode is frozen once it feeds the core clock as the sub clock
  assign sub_locked   = (act_cfg.sys_clk_sel == `SCMC_SEL_SUB) && act_cfg.lo_src_sel;

  // System clock register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scc_q <= `SCMC_RST_SYS_CLK;
    end else if (aph_q.valid && aph_q.write && (aph_q.addr == `SCMC_OFS_SYS_CLK)) begin
      scc_q        <= hwdata[7:0]; // R14
      scc_q.unused <= 1'b0;
    end
  end

  // Fast RC register; a frequency change or enable restarts the stable flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_rc_q <= 4'(`SCMC_RST_FAST_RC);
    end else begin
      fast_rc_q.stable_flag <= fast_rc_q.enable && fast_rc_ready;
      if (wr_fast_rc) begin
        fast_rc_q.mode   <= hwdata[`SCMC_OSC_MODE_MSB:`SCMC_OSC_MODE_LSB];
        fast_rc_q.enable <= hwdata[`SCMC_OSC_EN];
        if ((hwdata[`SCMC_OSC_MODE_MSB:`SCMC_OSC_MODE_LSB] != fast_rc_q.mode) ||
            (hwdata[`SCMC_OSC_EN] && !fast_rc_q.enable)) begin
          fast_rc_q.stable_flag <= 1'b0;
        end
      end
    end
  end

  // Fast crystal register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_xtal_q <= 4'(`SCMC_RST_FAST_XTAL);
    end else begin
      fast_xtal_q.stable_flag <= fast_xtal_q.enable && fast_xtal_ready && !(wr_fast_xtal && !fast_xtal_q.enable);
      fast_xtal_q.mode[1]     <= 1'b0;
      if (wr_fast_xtal) begin
        fast_xtal_q.mode[0] <= hwdata[`SCMC_OSC_MODE_LSB];
        fast_xtal_q.enable  <= hwdata[`SCMC_OSC_EN];
      end
    end
  end

  // Slow crystal register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_xtal_q <= 4'(`SCMC_RST_SLOW_XTAL);
    end else begin
      slow_xtal_q.stable_flag <= slow_xtal_q.enable && slow_xtal_ready && !(wr_slow_xtal && !slow_xtal_q.enable);
      slow_xtal_q.mode[1]     <= 1'b0;
      if (wr_slow_xtal) begin
        slow_xtal_q.enable <= hwdata[`SCMC_OSC_EN];
        if (!sub_locked) begin
          slow_xtal_q.mode[0] <= hwdata[`SCMC_OSC_MODE_LSB];
        end
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    case (haddr)
      `SCMC_OFS_SYS_CLK:   rd_val = scc_q;
      `SCMC_OFS_FAST_RC:   rd_val = {4'h0, fast_rc_q};
      `SCMC_OFS_FAST_XTAL: rd_val = {4'h0, fast_xtal_q};
      `SCMC_OFS_SLOW_XTAL: rd_val = {4'h0, slow_xtal_q};
      `SCMC_OFS_STATUS:    rd_val = {switch_busy, 1'b0, act_cfg, 1'b0} | {5'h00, mode_q};
      default:             rd_val = 8'h00;
    endcase
  end

  // Read data sampled at the address phase, stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata_q <= {24'h000000, rd_val};
    end
  end

  assign hrdata = hrdata_q;

  // Checks
  sleep_all_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    (mode_q == scmc_pkg::MODE_SLEEP) |-> !(core_clk_tick || cpu_clk_tick || fast_clk_tick || sub_clk_tick))
    else $error("clock strobe seen in sleep");
  sleep_internal_slow_rc_a: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    (mode_q == scmc_pkg::MODE_SLEEP) |-> (slow_rc_clk_tick == (slow_rc_tick && watchdog_en)))
    else $error("slow RC strobe wrong in sleep");
  halt_idle_slow_on_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    (in_run && halt_req && !scc_q.hi_keep_on_halt && scc_q.lo_keep_on_halt) |=> (mode_q == scmc_pkg::MODE_IDLE_SLOW_ON))
    else $error("halt with keeps 01 missed idle_slow_on");
  idle_both_on_clocks_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (mode_q == scmc_pkg::MODE_IDLE_BOTH_ON) |-> (fast_clk_tick == fast_src_tick) && (sub_clk_tick == sub_src_tick))
    else $error("idle_both_on stopped a clock");
  idle_fast_on_sub_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    (mode_q == scmc_pkg::MODE_IDLE_FAST_ON && act_cfg.sys_clk_sel != `SCMC_SEL_SUB) |-> !sub_clk_tick)
    else $error("sub clock running in idle_fast_on");
  cpu_stopped_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    !in_run |-> !cpu_clk_tick)
    else $error("CPU clock while halted");
  switch_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    $rose(switch_busy) |-> switch_busy[*5])
    else $error("source switch finished too early");
  fast_run_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    (mode_q == scmc_pkg::MODE_FAST) |-> (fast_clk_tick == fast_src_tick) && (slow_rc_clk_tick == slow_rc_tick))
    else $error("clock stopped in fast run");
  slow_core_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (mode_q == scmc_pkg::MODE_SLOW && !switch_busy && act_cfg.sys_clk_sel == `SCMC_SEL_SUB)
      |-> (core_clk_tick == sub_src_tick))
    else $error("slow run core clock not the sub clock");

  sleep_entry_c: cover property (@(posedge hclk) disable iff (!hresetn) in_run && halt_req ##1 mode_q == scmc_pkg::MODE_SLEEP);
  switch_done_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(switch_busy));
  idle_slow_on_core_c:  cover property (@(posedge hclk) disable iff (!hresetn) mode_q == scmc_pkg::MODE_IDLE_SLOW_ON && core_clk_tick);

endmodule : scmc_top

// ---- verification/scmc_tb.sv ----
// Self-checking bench for the clock and mode control
`timescale 1ns/1ps
`include "scmc_params.svh"

module tb;
  logic        hclk, hresetn, hsel, hwrite;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  wire logic   hready;
  logic        hreadyout, hresp;
  logic        fast_rc_tick, fast_xtal_tick, slow_rc_tick, slow_xtal_tick;
  logic        fast_rc_ready, fast_xtal_ready, slow_xtal_ready, watchdog_en, halt_req, wake_req;
  logic        core_clk_tick, cpu_clk_tick, fast_clk_tick, sub_clk_tick, slow_rc_clk_tick;
  logic [2:0]  op_mode;
  logic        switch_busy, meas;
  logic        fast_rc_osc_on, fast_xtal_osc_on, slow_xtal_osc_on, slow_rc_osc_on;
  logic [31:0] rng, rv;
  int          err_count, compares, cyc_count, tcnt, n_core, n_cpu, n_fast, n_sub, n_lrc, k, s;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  scmc_top #(.DIV_W(6)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fast_rc_tick(fast_rc_tick), .fast_xtal_tick(fast_xtal_tick), .slow_rc_tick(slow_rc_tick),
    .slow_xtal_tick(slow_xtal_tick), .fast_rc_ready(fast_rc_ready), .fast_xtal_ready(fast_xtal_ready),
    .slow_xtal_ready(slow_xtal_ready), .watchdog_en(watchdog_en), .halt_req(halt_req), .wake_req(wake_req),
    .core_clk_tick(core_clk_tick), .cpu_clk_tick(cpu_clk_tick), .fast_clk_tick(fast_clk_tick),
    .sub_clk_tick(sub_clk_tick), .slow_rc_clk_tick(slow_rc_clk_tick), .fast_rc_osc_on(fast_rc_osc_on),
    .fast_xtal_osc_on(fast_xtal_osc_on), .slow_xtal_osc_on(slow_xtal_osc_on),
    .slow_rc_osc_on(slow_rc_osc_on), .op_mode(op_mode),
    .switch_busy(switch_busy));

  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  // Oscillator strobes at fixed rates so tick counts are predictable
  always @(posedge hclk) begin
    tcnt <= tcnt + 1;
    fast_rc_tick <= 1'b1;
    fast_xtal_tick <= (tcnt % 2 == 0);
    slow_rc_tick <= (tcnt % 8 == 0);
    slow_xtal_tick <= (tcnt % 5 == 0);
  end

  // Tick counting on the falling edge, where combinational strobes are settled
  always @(negedge hclk) begin
    if (meas) begin
      n_core += int'(core_clk_tick);
      n_cpu += int'(cpu_clk_tick);
      n_fast += int'(fast_clk_tick);
      n_sub += int'(sub_clk_tick);
      n_lrc += int'(slow_rc_clk_tick);
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge hclk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 60000) begin
      err_count++;
      results();
    end
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  // Tolerance of one tick for phase of the counting window
  function automatic int near(int got, int exp);
    return (got >= exp - 1 && got <= exp + 1) ? exp : got;
  endfunction : near

  // Expected mode from the two keep bits
  function automatic int exp_mode(int kk);
    case (kk)
      0: return 2;
      1: return 3;
      2: return 5;
      default: return 4;
    endcase
  endfunction : exp_mode

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb_xfer

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb_xfer(a, 1'b0, 32'h00000000);
    chk(rd, exp);
  endtask : rd_chk

  // Write the system clock register and let any source switch finish
  task set_scc(input logic [7:0] v);
    int i;
    int b;
    ahb_xfer(`SCMC_OFS_SYS_CLK, 1'b1, {24'h000000, v});
    i = 0;
    while (switch_busy !== 1'b1 && i < 20) begin
      @(posedge hclk);
      i++;
    end
    b = 0;
    while (switch_busy === 1'b1 && b < 3000) begin
      @(posedge hclk);
      b++;
    end
    if (i < 20) chk(32'(b >= 4), 32'h1);
  endtask : set_scc

  task measure(input int n);
    n_core = 0; n_cpu = 0; n_fast = 0; n_sub = 0; n_lrc = 0;
    meas = 1'b1;
    repeat (n) @(posedge hclk);
    meas = 1'b0;
  endtask : measure

  task pulse(input logic wk);
    @(posedge hclk);
    if (wk) wake_req <= 1'b1; else halt_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    halt_req <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : pulse

  task results();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h00000000;
    fast_rc_ready = 1'b1; fast_xtal_ready = 1'b1; slow_xtal_ready = 1'b1; watchdog_en = 1'b0;
    halt_req = 1'b0; wake_req = 1'b0; meas = 1'b0; rng = 32'hC5CD76C3; tcnt = 0;
    err_count = 0; compares = 0; cyc_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped place ignored on write and zero on read
    ahb_xfer(8'h14, 1'b1, 32'hFFFFFFFF);
    rd_chk(`SCMC_OFS_SYS_CLK, 32'(`SCMC_RST_SYS_CLK));
    rd_chk(`SCMC_OFS_FAST_RC, 32'h00000003);
    rd_chk(`SCMC_OFS_FAST_XTAL, 32'(`SCMC_RST_FAST_XTAL));
    rd_chk(8'h14, 32'h00000000);
    chk(32'({hreadyout, hresp}), 32'h2);
    // Every divide ratio of the fast clock
    for (k = 0; k < 7; k++) begin
      set_scc({k[2:0], 5'h00});
      measure(128);
      chk(32'(near(n_core, 128 >> k)), 32'(128 >> k));
      chk(32'(n_cpu), 32'(n_core));
      chk(32'(n_fast), 32'h80);
      chk(32'(op_mode), 32'h0);
    end
    // Crystal sources, then the sub clock from each slow source
    ahb_xfer(`SCMC_OFS_FAST_XTAL, 1'b1, 32'h00000005);
    ahb_xfer(`SCMC_OFS_SLOW_XTAL, 1'b1, 32'h00000001);
    repeat (4) @(posedge hclk);
    rd_chk(`SCMC_OFS_FAST_XTAL, 32'h00000007);
    rd_chk(`SCMC_OFS_SLOW_XTAL, 32'h00000003);
    set_scc(8'h08);
    measure(128);
    chk(32'(near(n_core, 64)), 32'h40);
    chk(32'(fast_xtal_osc_on), 32'h1);
    set_scc(8'hE0);
    measure(128);
    chk(32'(near(n_core, 16)), 32'h10);
    chk(32'(op_mode), 32'h1);
    chk(32'(n_fast > 0), 32'h1);
    set_scc(8'hE4);
    measure(128);
    chk(32'(near(n_core, 25)), 32'h19);
    chk(32'(slow_xtal_osc_on), 32'h1);
    // Random settings read back with the empty bit cleared
    repeat (3) begin
      // Own variable: the bus task overwrites rd with read data
      rv = xs();
      set_scc(rv[7:0]);
      rd_chk(`SCMC_OFS_SYS_CLK, {24'h000000, rv[7:0] & 8'hEF});
    end
    // Each keep combination with fast and with sub core clock
    for (s = 0; s < 2; s++) begin
      for (k = 0; k < 4; k++) begin
        rd = xs();
        watchdog_en <= rd[0];
        set_scc({(s == 1) ? 3'h7 : 3'h0, 3'h0, k[1:0]});
        pulse(1'b0);
        chk(32'(op_mode), 32'(exp_mode(k)));
        chk(32'(fast_rc_osc_on), 32'(k[1]));
        chk(32'(slow_rc_osc_on), 32'(k != 0 || watchdog_en));
        measure(64);
        chk(32'(n_cpu), 32'h0);
        chk(32'(n_core > 0), 32'(k == 3 || (k == 1 && s == 1) || (k == 2 && s == 0)));
        chk(32'(n_fast > 0), 32'(k[1]));
        chk(32'(n_sub > 0), 32'(k[0] | (k == 2 && s == 1)));
        if (k == 0) chk(32'(n_lrc > 0), 32'(watchdog_en));
        pulse(1'b1);
        chk(32'(op_mode), 32'(s));
      end
    end
    results();
  end
endmodule : tb
